/* rtl/spu_consts.vh */
// Constants for the serial port control block.
// Included by the design, checker and bench files; definitions, no logic.
`ifndef SPU_CONSTS_VH
`define SPU_CONSTS_VH
// Register indices; the APB byte address is four times the index
`define SPU_IDX_PWR 8'h87
`define SPU_IDX_SER 8'h98
// Register byte addresses (APB, one aligned word each)
`define SPU_ADDR_PWR 12'h21C
`define SPU_ADDR_SER 12'h260
`define SPU_ADDR_TXD 12'h300
`define SPU_ADDR_RXD 12'h304
`define SPU_ADDR_CFG 12'h308
`define SPU_ADDR_IST 12'h30C
`define SPU_ADDR_IMK 12'h310
// Reset values
`define SPU_PWR_RST 8'h10
`define SPU_SER_RST 8'h00
`define SPU_CFG_RST 4'h0
// Field positions in the serial control register
`define SPU_SER_B7 7
`define SPU_SER_MH 6
`define SPU_SER_MF 5
`define SPU_SER_REN 4
`define SPU_SER_TX9 3
`define SPU_SER_RX9 2
`define SPU_SER_TDONE 1
`define SPU_SER_RDONE 0
// Field positions in the power control register
`define SPU_PWR_DBL 7
`define SPU_PWR_FSEL 6
// Field positions in the configuration register
`define SPU_CFG_CLK12 0
`define SPU_CFG_TXT2 1
`define SPU_CFG_RXT2 2
// Interrupt status bits
`define SPU_IRQ_TX 0
`define SPU_IRQ_RX 1
`define SPU_IRQ_FE 2
// Oscillator divisors
`define SPU_DIV_M0_6 8'd6
`define SPU_DIV_M0_12 8'd12
`define SPU_DIV_M2_6_SLOW 8'd32
`define SPU_DIV_M2_6_FAST 8'd16
`define SPU_DIV_M2_12_SLOW 8'd64
`define SPU_DIV_M2_12_FAST 8'd32
// Oversampling of a bit time by baud ticks (timer overflows, or the fixed-rate tick in mode 2)
`define SPU_OVS_NORM 5'd16
`define SPU_OVS_DBL 5'd8
`define SPU_OVS_M2 5'd16
// Mode codes (mode_sel_low, mode_sel_high)
`define SPU_MODE0 2'b00
`define SPU_MODE1 2'b01
`define SPU_MODE2 2'b10
`define SPU_MODE3 2'b11
`endif

/* rtl/spu_serial.v */
// Serial port control: four-mode UART with APB registers and one interrupt.
// Assumes timer overflow pulses arrive on mclk_in and serial pins are asynchronous.
// What this block does
// - Two mode bits select one of four modes
// - Baud double bit doubles async mode rates
// - Function select makes bit 7 mode or error
// - Bad stop bit sets sticky frame error
// - Modes 2/3 filter: ninth bit and address
// - Mode 1 filter: need valid stop bit
// - Receive only while receive enable set
// - Modes 2/3 send written ninth bit
// - Ninth receive bit holds data, or stop with mode 1 filter off
// - Transmit done at bit 8 or stop start
// - Receive done at bit 8 or mid stop
// - Modes 1/3 clock from timer 1 or 2
`timescale 1ns/1ps
`default_nettype none
`include "spu_consts.vh"
module spu_serial #(
    parameter [7:0] OWN_ADDR = 8'h00,
    parameter [7:0] BCAST_ADDR = 8'hFF
) (
    // Clock and reset
    input wire mclk_in,
    input wire nrst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // Baud sources
    input wire t1_ovf_in,
    input wire t2_ovf_in,
    // Serial line
    input wire rxd_in,
    output reg txd_out,
    output reg rxd_out,
    output reg rxd_oe_out,
    // Interrupt
    output wire irq_out
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    reg [7:0] pwr_reg;
    reg [7:0] ser_reg;
    reg fe_reg;
    reg [3:0] cfg_reg;
    reg [2:0] ist_reg;
    reg [2:0] imk_reg;
    reg [7:0] rxbuf_reg;
    reg [7:0] txd_buf;
    reg [2:0] rx_sync_reg;
    reg rx_line_reg;
    wire [1:0] mode = {ser_reg[`SPU_SER_B7], ser_reg[`SPU_SER_MH]};
    wire dbl = pwr_reg[`SPU_PWR_DBL];
    wire clk12 = cfg_reg[`SPU_CFG_CLK12];
    wire wr = psel_in & penable_in & pwrite_in;
    // Pin synchroniser: change taken once stages two and three agree
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_sync_reg <= 3'b111;
            rx_line_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rxd_in};
            if (rx_sync_reg[2] == rx_sync_reg[1]) begin
                rx_line_reg <= rx_sync_reg[2];
            end
        end
    end
    // Fixed-rate tick for modes 0 and 2
    reg [7:0] fdiv_reg;
    reg [7:0] fdiv_lim;
    always @* begin
        if (mode == `SPU_MODE0) begin
            fdiv_lim = clk12 ? `SPU_DIV_M0_12 : `SPU_DIV_M0_6;
        end else if (dbl) begin
            fdiv_lim = clk12 ? `SPU_DIV_M2_12_FAST : `SPU_DIV_M2_6_FAST;
        end else begin
            fdiv_lim = clk12 ? `SPU_DIV_M2_12_SLOW : `SPU_DIV_M2_6_SLOW;
        end
    end
    // Mode 0 ticks each half bit, as the shift clock toggles once per tick
    // Mode 2 ticks run 16 per bit, so the oscillator divisor is split by 16
    wire [7:0] fdiv_top = (mode == `SPU_MODE0) ? (fdiv_lim >> 1) - 8'd1 :
                          (fdiv_lim >> 4) - 8'd1;
    wire ftick = (fdiv_reg >= fdiv_top);
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fdiv_reg <= 8'h00;
        end else begin
            fdiv_reg <= ftick ? 8'h00 : fdiv_reg + 8'd1;
        end
    end
    // Oversample ticks per bit: doubling halves this in modes 1 and 3
    wire [4:0] ovs = (mode == `SPU_MODE2) ? `SPU_OVS_M2 : (dbl ? `SPU_OVS_DBL : `SPU_OVS_NORM);
    wire tx_tick = (mode == `SPU_MODE2) ? ftick :
                   (cfg_reg[`SPU_CFG_TXT2] ? t2_ovf_in : t1_ovf_in);
    wire rx_tick = (mode == `SPU_MODE2) ? ftick :
                   (cfg_reg[`SPU_CFG_RXT2] ? t2_ovf_in : t1_ovf_in);
    // Transmitter
    reg tx_st_reg;
    reg [10:0] tx_sh_reg;
    reg [3:0] tx_cnt_reg;
    reg [4:0] tx_ph_reg;
    reg tx_go_reg;
    reg tx_set;
    wire nine = mode[1];
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_st_reg <= ST_IDLE;
            tx_sh_reg <= 11'h7FF;
            tx_cnt_reg <= 4'h0;
            tx_ph_reg <= 5'h00;
            txd_out <= 1'b1;
            tx_set <= 1'b0;
            rxd_out <= 1'b1;
            rxd_oe_out <= 1'b0;
        end else begin
            tx_set <= 1'b0;
            case (tx_st_reg)
                ST_IDLE: begin
                    txd_out <= 1'b1;
                    rxd_oe_out <= 1'b0;
                    if (tx_go_reg) begin
                        tx_st_reg <= ST_RUN;
                        tx_ph_reg <= 5'h00;
                        tx_cnt_reg <= 4'h0;
                        if (mode == `SPU_MODE0) begin
                            tx_sh_reg <= {3'b111, txd_buf};
                            rxd_oe_out <= 1'b1;
                            rxd_out <= txd_buf[0];
                        end else begin
                            // Start, data lsb first, ninth bit, stop
                            tx_sh_reg <= {1'b1, nine ? ser_reg[`SPU_SER_TX9] : 1'b1, txd_buf, 1'b0};
                        end
                    end
                end
                default: begin
                    if (mode == `SPU_MODE0) begin
                        // Shift clock on txd: low half then high half of each bit
                        if (ftick) begin
                            txd_out <= ~txd_out;
                            if (txd_out == 1'b0) begin
                                tx_cnt_reg <= tx_cnt_reg + 4'd1;
                                tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
                                rxd_out <= tx_sh_reg[1];
                                if (tx_cnt_reg == 4'd7) begin
                                    tx_set <= 1'b1;
                                    tx_st_reg <= ST_IDLE;
                                end
                            end
                        end
                    end else begin
                        txd_out <= tx_sh_reg[0];
                        if (tx_tick) begin
                            tx_ph_reg <= tx_ph_reg + 5'd1;
                            if (tx_ph_reg == ovs - 5'd1) begin
                                tx_ph_reg <= 5'h00;
                                tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
                                tx_cnt_reg <= tx_cnt_reg + 4'd1;
                                // Flag as the stop bit begins
                                if (tx_cnt_reg == (nine ? 4'd9 : 4'd8)) begin
                                    tx_set <= 1'b1;
                                end
                                if (tx_cnt_reg == (nine ? 4'd10 : 4'd9)) begin
                                    tx_st_reg <= ST_IDLE;
                                end
                            end
                        end
                    end
                end
            endcase
        end
    end
    // Receiver
    reg rx_st_reg;
    reg [9:0] rx_sh_reg;
    reg [3:0] rx_cnt_reg;
    reg [4:0] rx_ph_reg;
    reg rx_set;
    reg fe_set;
    reg rx9_val;
    reg rx9_upd;
    wire rx_addr_ok = (rx_sh_reg[8:1] == OWN_ADDR) || (rx_sh_reg[8:1] == BCAST_ADDR);
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_st_reg <= ST_IDLE;
            rx_sh_reg <= 10'h000;
            rx_cnt_reg <= 4'h0;
            rx_ph_reg <= 5'h00;
            rx_set <= 1'b0;
            fe_set <= 1'b0;
            rx9_val <= 1'b0;
            rx9_upd <= 1'b0;
            rxbuf_reg <= 8'h00;
        end else begin
            rx_set <= 1'b0;
            fe_set <= 1'b0;
            rx9_upd <= 1'b0;
            if (!ser_reg[`SPU_SER_REN]) begin
                rx_st_reg <= ST_IDLE;
            end else if (rx_st_reg == ST_IDLE) begin
                // Mode 0 waits for a receive-done clear before sampling, as is usual
                if ((mode != `SPU_MODE0 && !rx_line_reg) ||
                    (mode == `SPU_MODE0 && !ser_reg[`SPU_SER_RDONE])) begin
                    rx_st_reg <= ST_RUN;
                    rx_ph_reg <= 5'h00;
                    rx_cnt_reg <= 4'h0;
                end
            end else if (mode == `SPU_MODE0) begin
                if (ftick && txd_out == 1'b1 && tx_st_reg == ST_IDLE) begin
                    rx_sh_reg <= {rx_line_reg, rx_sh_reg[9:1]};
                    rx_cnt_reg <= rx_cnt_reg + 4'd1;
                    if (rx_cnt_reg == 4'd7) begin
                        rxbuf_reg <= {rx_line_reg, rx_sh_reg[9:3]};
                        rx_set <= 1'b1;
                        rx_st_reg <= ST_IDLE;
                    end
                end
            end else if (rx_tick) begin
                rx_ph_reg <= rx_ph_reg + 5'd1;
                if (rx_ph_reg == (ovs >> 1)) begin
                    // Sample at mid bit
                    if (rx_cnt_reg == 4'd0 && rx_line_reg) begin
                        rx_st_reg <= ST_IDLE;
                    end else if (rx_cnt_reg == (nine ? 4'd10 : 4'd9)) begin
                        rx_st_reg <= ST_IDLE;
                        fe_set <= ~rx_line_reg;
                        if (!ser_reg[`SPU_SER_RDONE]) begin
                            if (nine) begin
                                if (!ser_reg[`SPU_SER_MF] || (rx_sh_reg[9] && rx_addr_ok)) begin
                                    rx_set <= 1'b1;
                                    rxbuf_reg <= rx_sh_reg[8:1];
                                    rx9_val <= rx_sh_reg[9];
                                    rx9_upd <= 1'b1;
                                end
                            end else if (!ser_reg[`SPU_SER_MF] || rx_line_reg) begin
                                rx_set <= 1'b1;
                                rxbuf_reg <= rx_sh_reg[9:2];
                                rx9_val <= rx_line_reg;
                                rx9_upd <= ~ser_reg[`SPU_SER_MF];
                            end
                        end
                    end else begin
                        rx_sh_reg <= {rx_line_reg, rx_sh_reg[9:1]};
                        rx_cnt_reg <= rx_cnt_reg + 4'd1;
                    end
                end
                if (rx_ph_reg == ovs - 5'd1) begin
                    rx_ph_reg <= 5'h00;
                end
            end
        end
    end
    // Registers; hardware sets win over software clears
    wire hit_ser = wr && paddr_in == `SPU_ADDR_SER;
    wire hit_pwr = wr && paddr_in == `SPU_ADDR_PWR;
    wire fsel = pwr_reg[`SPU_PWR_FSEL];
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_reg <= `SPU_PWR_RST;
            ser_reg <= `SPU_SER_RST;
            fe_reg <= 1'b0;
            cfg_reg <= `SPU_CFG_RST;
            ist_reg <= 3'b000;
            imk_reg <= 3'b000;
            txd_buf <= 8'h00;
            tx_go_reg <= 1'b0;
        end else begin
            tx_go_reg <= 1'b0;
            if (hit_pwr) begin
                pwr_reg <= pwdata_in[7:0];
            end
            if (hit_ser) begin
                ser_reg[6:0] <= pwdata_in[6:0];
                if (fsel) begin
                    fe_reg <= pwdata_in[`SPU_SER_B7];
                end else begin
                    ser_reg[`SPU_SER_B7] <= pwdata_in[`SPU_SER_B7];
                end
            end
            if (wr && paddr_in == `SPU_ADDR_TXD && tx_st_reg == ST_IDLE) begin
                txd_buf <= pwdata_in[7:0];
                tx_go_reg <= 1'b1;
            end
            if (wr && paddr_in == `SPU_ADDR_CFG) begin
                cfg_reg <= pwdata_in[3:0];
            end
            if (wr && paddr_in == `SPU_ADDR_IMK) begin
                imk_reg <= pwdata_in[2:0];
            end
            if (wr && paddr_in == `SPU_ADDR_IST) begin
                ist_reg <= (ist_reg & ~pwdata_in[2:0]) | {fe_set, rx_set, tx_set};
            end else begin
                ist_reg <= ist_reg | {fe_set, rx_set, tx_set};
            end
            if (tx_set) begin
                ser_reg[`SPU_SER_TDONE] <= 1'b1;
            end
            if (rx_set) begin
                ser_reg[`SPU_SER_RDONE] <= 1'b1;
            end
            if (rx9_upd) begin
                ser_reg[`SPU_SER_RX9] <= rx9_val;
            end
            if (fe_set) begin
                fe_reg <= 1'b1;
            end
        end
    end
    assign irq_out = |(ist_reg & imk_reg);
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    // Read word is captured in the setup cycle, so it stands through the access
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0000_0000;
        if (paddr_in == `SPU_ADDR_PWR) begin
            rd_word = {24'h00_0000, pwr_reg};
        end else if (paddr_in == `SPU_ADDR_SER) begin
            rd_word = {24'h00_0000, fsel ? fe_reg : ser_reg[`SPU_SER_B7], ser_reg[6:0]};
        end else if (paddr_in == `SPU_ADDR_RXD) begin
            rd_word = {24'h00_0000, rxbuf_reg};
        end else if (paddr_in == `SPU_ADDR_CFG) begin
            rd_word = {28'h000_0000, cfg_reg};
        end else if (paddr_in == `SPU_ADDR_IST) begin
            rd_word = {29'h0000_0000, ist_reg};
        end else if (paddr_in == `SPU_ADDR_IMK) begin
            rd_word = {29'h0000_0000, imk_reg};
        end
    end
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            prdata_out <= rd_word;
        end
    end
endmodule
`default_nettype wire

/* verif/spu_serial_checker.sv */
// Concurrent checks on the serial port block, seen from its ports only.
// Assumes APB writes take effect at the access edge and the line idles high.
`timescale 1ns/1ps
`default_nettype none
`include "spu_consts.vh"
module spu_serial_checker (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Line and interrupt
    input wire logic txd_out,
    input wire logic rxd_oe_out,
    input wire logic irq_out
);
    logic [1:0] mode_reg;
    logic fsel_reg;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // Shadow of the mode; bit 7 is a mode bit only while function select is clear
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_reg <= 2'b00;
            fsel_reg <= 1'b0;
        end else if (psel_in && penable_in && pwrite_in) begin
            if (paddr_in == `SPU_ADDR_PWR) fsel_reg <= pwdata_in[`SPU_PWR_FSEL];
            if (paddr_in == `SPU_ADDR_SER) begin
                mode_reg[0] <= pwdata_in[`SPU_SER_MH];
                if (!fsel_reg) mode_reg[1] <= pwdata_in[`SPU_SER_B7];
            end
        end
    end
    sequence frame_start;
        $fell(txd_out) && mode_reg != 2'b00;
    endsequence
    ready_no_err_a: assert property (psel_in && penable_in |-> pready_out && !pslverr_out)
        else $error("apb answer not ready or error");
    unmapped_zero_a: assert property (psel_in && penable_in && !pwrite_in && paddr_in == 12'h314
        |-> prdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (psel_in && !pwrite_in |-> prdata_out[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    reset_out_a: assert property (!$past(nrst_in) |-> txd_out && !rxd_oe_out && !irq_out)
        else $error("outputs not idle after reset");
    async_no_oe_a: assert property (mode_reg != 2'b00 && $past(mode_reg) != 2'b00 |-> !rxd_oe_out)
        else $error("data pin driven in uart mode");
    start_hold_a: assert property (frame_start |-> !txd_out [*8])
        else $error("start bit too short");
    frame_end_a: assert property (frame_start |-> ##[1:800] txd_out)
        else $error("line not back high");
    tx_launch_a: assert property (psel_in && penable_in && pwrite_in && paddr_in == `SPU_ADDR_TXD
        && mode_reg != 2'b00 && txd_out |-> ##[1:3] !txd_out)
        else $error("send did not start");
endmodule
`default_nettype wire

/* verif/spu_remote.sv */
// Remote serial device: sends frames onto the receive pin, captures transmitted frames.
// Assumes the caller enters each task just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module spu_remote (
    // Clock
    input wire logic mclk_in,
    // Line
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    task automatic send(input logic [8:0] v, input int nb, input logic st, input int bt);
        line_out <= 1'b0;
        repeat (bt) @(posedge mclk_in);
        for (int i = 0; i < nb; i++) begin
            line_out <= v[i];
            repeat (bt) @(posedge mclk_in);
        end
        line_out <= st;
        repeat (bt) @(posedge mclk_in);
        // Idle high, one extra bit so the mid-stop flag has landed
        line_out <= 1'b1;
        repeat (bt) @(posedge mclk_in);
    endtask
    // Stop bit lands at index nb; sampled mid-bit
    task automatic recv(input int nb, input int bt, output logic [9:0] v);
        int n;
        n = 0;
        v = 10'h000;
        while (line_in !== 1'b0 && n < 5000) begin
            @(posedge mclk_in);
            n++;
        end
        repeat (bt / 2) @(posedge mclk_in);
        for (int i = 0; i <= nb; i++) begin
            repeat (bt) @(posedge mclk_in);
            v[i] = line_in;
        end
    endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the serial port block over APB.
// Assumes timer pulses every 2 (timer 1) and 3 (timer 2) cycles.
`timescale 1ns/1ps
`default_nettype none
`include "spu_consts.vh"
module tb_top;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rdata;
    logic pready_out, pslverr_out, t1_ovf_in = 1'b0, t2_ovf_in = 1'b0;
    logic rxd_in, txd_out, rxd_out, rxd_oe_out, irq_out;
    logic [9:0] got;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #25 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        t1_ovf_in <= (cyc % 2 == 0);
        t2_ovf_in <= (cyc % 3 == 0);
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end
    spu_serial spu_serial_inst (.mclk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .t1_ovf_in,
        .t2_ovf_in, .rxd_in, .txd_out, .rxd_out, .rxd_oe_out, .irq_out);
    spu_remote spu_remote_inst (.mclk_in, .line_in(txd_out), .line_out(rxd_in));
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Read data is taken at the edge that completes the access
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        @(posedge mclk_in);
        while (pready_out !== 1'b1) @(posedge mclk_in);
        rdata = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic do_tx(input logic [7:0] pc, cf, sc, d, input int nb, bt);
        logic [9:0] e;
        e = (nb == 9) ? {1'b1, sc[3], d} : {2'b01, d};
        wr(`SPU_ADDR_PWR, pc);
        wr(`SPU_ADDR_CFG, cf);
        wr(`SPU_ADDR_SER, sc);
        fork
            wr(`SPU_ADDR_TXD, d);
            spu_remote_inst.recv(nb, bt, got);
        join
        chk(32'(got), 32'(e));
        rd(`SPU_ADDR_SER);
        chk(32'(rdata[1]), 32'h0000_0001);
        // Let the stop bit run out before the next frame is set up
        repeat (bt) @(posedge mclk_in);
    endtask
    task automatic do_rx(input logic [7:0] pc, sc, input logic [8:0] v, input int nb,
        input logic st, ri);
        wr(`SPU_ADDR_PWR, pc);
        wr(`SPU_ADDR_CFG, 8'h00);
        wr(`SPU_ADDR_SER, sc);
        spu_remote_inst.send(v, nb, st, 32);
        rd(`SPU_ADDR_SER);
        chk(32'(rdata[7]), 32'(pc[6] ? !st : sc[7]));
        if (!pc[6]) chk(32'(rdata[0]), 32'(ri));
        if (ri) begin
            chk(32'(rdata[2]), 32'(nb == 9 ? v[8] : st));
            rd(`SPU_ADDR_RXD);
            chk(32'(rdata[7:0]), 32'(v[7:0]));
        end
        wr(`SPU_ADDR_SER, 8'h00);
        wr(`SPU_ADDR_IST, 8'h07);
    endtask
    initial begin
        repeat (4) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        rd(`SPU_ADDR_PWR);
        chk(rdata, 32'h0000_0010);
        rd(`SPU_ADDR_SER);
        chk(rdata, 32'h0000_0000);
        rd(12'h314);
        chk(rdata, 32'h0000_0000);
        do_tx(8'h00, 8'h00, 8'h40, 8'hA5, 8, 32);
        do_tx(8'h80, 8'h00, 8'h40, 8'h3C, 8, 16);
        do_tx(8'h00, 8'h02, 8'hC8, 8'h96, 9, 48);
        do_tx(8'h80, 8'h00, 8'hC0, 8'h0F, 9, 16);
        do_tx(8'h00, 8'h00, 8'h88, 8'h81, 9, 32);
        do_tx(8'h80, 8'h00, 8'h80, 8'h7E, 9, 16);
        do_tx(8'h00, 8'h01, 8'h88, 8'h00, 9, 64);
        do_tx(8'h80, 8'h01, 8'h80, 8'hFF, 9, 32);
        rd(`SPU_ADDR_IST);
        chk(32'(rdata[0]), 32'h0000_0001);
        chk(32'(irq_out), 32'h0000_0000);
        wr(`SPU_ADDR_IMK, 8'h01);
        chk(32'(irq_out), 32'h0000_0001);
        wr(`SPU_ADDR_IST, 8'h01);
        chk(32'(irq_out), 32'h0000_0000);
        wr(`SPU_ADDR_IMK, 8'h00);
        wr(`SPU_ADDR_CFG, 8'h01);
        wr(`SPU_ADDR_SER, 8'h00);
        fork
            begin
                wr(`SPU_ADDR_TXD, 8'h35);
                // Eight shift clocks of twelve cycles, with margin
                repeat (150) @(posedge mclk_in);
                rd(`SPU_ADDR_SER);
                chk(32'(rdata[1]), 32'h0000_0001);
            end
            // Data pin is steady while the shift clock is low
            for (int i = 0; i < 8; i++) begin
                @(negedge txd_out);
                got[i] = rxd_out & rxd_oe_out;
            end
        join
        chk(32'(got[7:0]), 32'h0000_0035);
        do_rx(8'h00, 8'h50, 9'h05A, 8, 1'b1, 1'b1);
        do_rx(8'h00, 8'h40, 9'h05A, 8, 1'b1, 1'b0);
        do_rx(8'h00, 8'h70, 9'h05A, 8, 1'b0, 1'b0);
        do_rx(8'h00, 8'hF0, 9'h0FF, 9, 1'b1, 1'b0);
        do_rx(8'h00, 8'hF0, 9'h133, 9, 1'b1, 1'b0);
        do_rx(8'h00, 8'hF0, 9'h1FF, 9, 1'b1, 1'b1);
        do_rx(8'h00, 8'hF0, 9'h100, 9, 1'b1, 1'b1);
        do_rx(8'h40, 8'h50, 9'h05A, 8, 1'b0, 1'b0);
        stop_test();
    end
endmodule
bind spu_serial spu_serial_checker spu_serial_checker_inst (.mclk_in, .nrst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .txd_out, .rxd_oe_out, .irq_out);
`default_nettype wire
